//--- hdl/rfph_consts.vh
/*
 constants for the radio queue and packet handler: register offsets, field positions,
 reset values, sizes and codes. assumes inclusion by bare name from the design files.
*/
`ifndef RFPH_CONSTS_VH
`define RFPH_CONSTS_VH

// ==========================================
// register offsets
`define RFPH_TXQ_WR_OFS      8'h66
`define RFPH_RXQ_RD_OFS      8'h77
`define RFPH_CTRL_OFS        8'h10
`define RFPH_PKT_CFG_OFS     8'h11
`define RFPH_TX_AE_OFS       8'h12
`define RFPH_RX_AF_OFS       8'h13
`define RFPH_SYNC_OFS        8'h14
`define RFPH_HDR_OFS         8'h15
`define RFPH_LEN_OFS         8'h16
`define RFPH_STATUS_OFS      8'h20
`define RFPH_EVENT_OFS       8'h21
`define RFPH_INT_EN_OFS      8'h22
`define RFPH_TXQ_CNT_OFS     8'h23
`define RFPH_RXQ_CNT_OFS     8'h24
`define RFPH_CLEAR_OFS       8'h25

// ==========================================
// control fields
`define RFPH_CTRL_TX_GO      0
`define RFPH_CTRL_RX_GO      1
`define RFPH_CTRL_PH_TX      2
`define RFPH_CTRL_PH_RX      3
`define RFPH_CTRL_SHARED     4
// packet field enables
`define RFPH_CFG_PRE         0
`define RFPH_CFG_SYNC        1
`define RFPH_CFG_HDR         2
`define RFPH_CFG_LEN         3
`define RFPH_CFG_CRC         4
`define RFPH_CFG_WHITE       5
`define RFPH_CFG_MANCH       6
// clear command bits
`define RFPH_CLR_TX          0
`define RFPH_CLR_RX          1
// event bits
`define RFPH_EV_TX_AE        0
`define RFPH_EV_RX_AF        1
`define RFPH_EV_SENT         2
`define RFPH_EV_PRE_OK       3
`define RFPH_EV_SYNC_OK      4
`define RFPH_EV_PKT_OK       5
`define RFPH_EV_CRC_ERR      6

// ==========================================
// sizes and reset values
`define RFPH_QDEPTH          64
`define RFPH_QDEPTH_SHARED   129
`define RFPH_CNT_W           8
`define RFPH_CTRL_RST        8'h00
`define RFPH_CFG_RST         8'h1f
`define RFPH_TX_AE_RST       8'h10
`define RFPH_RX_AF_RST       8'h30
`define RFPH_SYNC_RST        8'h2d
`define RFPH_HDR_RST         8'h00
`define RFPH_LEN_RST         8'h08
`define RFPH_PRE_BYTE        8'haa
`define RFPH_PRE_TX_BYTES    8'h04
`define RFPH_PRE_RX_BYTES    8'h02
`define RFPH_WHITE_SEED      8'hff
`define RFPH_CRC_SEED        8'hff

`endif

//--- hdl/rfph_queue.v
/*
 byte queue with a capacity chosen at run time between its normal and its shared size.
 assumes one clock; push and pop are single-cycle strobes.
*/
`timescale 1ns/1ps
`include "rfph_consts.vh"

module rfph_queue (
   input  wire       core_clk,
   input  wire       srst,
   input  wire       clear,
   input  wire       big,
   input  wire       push,
   input  wire [7:0] push_data,
   input  wire       pop,
   output reg  [7:0] pop_data,
   output wire [7:0] fill,
   output wire       full,
   output wire       empty
);
   reg  [7:0] mem [0:`RFPH_QDEPTH_SHARED-1];
   reg  [7:0] wr_reg;
   reg  [7:0] rd_reg;
   reg  [7:0] cnt_reg;
   wire [7:0] cap;
   wire       do_push;
   wire       do_pop;

   function [7:0] wrap_inc;
      input [7:0] p;
      input [7:0] c;
      begin
         wrap_inc = (p == c - 8'h01) ? 8'h00 : p + 8'h01;
      end
   endfunction

   assign cap     = big ? 8'd129 : 8'd64;
   assign full    = (cnt_reg >= cap);
   assign empty   = (cnt_reg == 8'h00);
   assign fill    = cnt_reg;
   // refused push or pop leaves the contents alone
   assign do_push = push & ~full;
   assign do_pop  = pop & ~empty;

   // head byte is shown ahead of the pop so a reader takes it in the pop cycle
   always @* begin
      pop_data = mem[rd_reg];
   end

   always @(posedge core_clk) begin
      if (srst || clear) begin
         wr_reg   <= 8'h00;
         rd_reg   <= 8'h00;
         cnt_reg  <= 8'h00;
      end else begin
         if (do_push) begin
            mem[wr_reg] <= push_data;
            wr_reg      <= wrap_inc(wr_reg, cap);
         end
         if (do_pop)
            rd_reg   <= wrap_inc(rd_reg, cap);
         case ({do_push, do_pop})
            2'b10:   cnt_reg <= cnt_reg + 8'h01;
            2'b01:   cnt_reg <= cnt_reg - 8'h01;
            default: cnt_reg <= cnt_reg;
         endcase
      end
   end
endmodule // rfph_queue

//--- hdl/rfph_top.v
/*
 transmit and receive queues with the packet framer and checker around them.
 assumes a host on the plain register port and a bit-serial modem on the line side,
 one bit per valid strobe, in the same clock domain.
*/
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "rfph_consts.vh"

// How it works
// - two 64-byte queues, transmit and receive
// - single-direction use gives 129-byte queue
// - writes to 66h push transmit bytes
// - reads from 77h pop receive bytes
// - event when transmit fill drops to level
// - transmitter stops itself after packet_transmitted_event if the transmit queue is empty
// - interrupt when receive fill crosses level
// - almost-full means threshold bytes are readable
// - clear command empties either or both queues
// - packet handling enabled per direction
// - each packet field enabled individually; transmit sends header and length only when preamble or sync is on
// - good preamble raises preamble-good event
// - matching sync word raises sync-found event
// - packet-good and checksum-failure events in receive
// - receive undoes whitening and Manchester coding
// - receive checks header, stores payload bytes
// - transmit builds preamble, sync, payload, checksum
// - transmit applies whitening and Manchester coding
// - interrupt request line is active low
module rfph_top (
   input  wire       core_clk,
   input  wire       srst,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire       tx_bit_ready,
   output reg        tx_bit,
   output reg        tx_bit_valid,
   input  wire       rx_bit,
   input  wire       rx_bit_valid,
   output reg        interrupt_request_n
);
   // ==========================================
   // registers
   reg  [7:0] ctrl_reg, cfg_reg, tx_ae_reg, rx_af_reg, sync_reg, hdr_reg, len_reg;
   reg  [6:0] event_reg, int_en_reg;
   reg  [6:0] ev_set;
   wire [7:0] txq_fill, rxq_fill, txq_data, rxq_data;
   wire       txq_empty, txq_full, rxq_full, rxq_empty;
   wire       wr_txq, rd_rxq, clr_tx, clr_rx;
   reg        rxq_push;
   reg  [7:0] rxq_pdata;
   reg        txq_pop;
   reg  [7:0] prev_tx_fill, prev_rx_fill;
   reg  [6:3] ev_rx;

   function [7:0] crc8_step;
      input [7:0] crc;
      input [7:0] b;
      integer i;
      reg [7:0] c;
      begin
         c = crc ^ b;
         for (i = 0; i < 8; i = i + 1)
            c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
         crc8_step = c;
      end
   endfunction

   function [7:0] lfsr_step;
      input [7:0] s;
      begin
         lfsr_step = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
      end
   endfunction

   assign wr_txq = reg_wr && (reg_addr == `RFPH_TXQ_WR_OFS);
   assign rd_rxq = reg_rd && (reg_addr == `RFPH_RXQ_RD_OFS);
   assign clr_tx = reg_wr && (reg_addr == `RFPH_CLEAR_OFS) && reg_wdata[`RFPH_CLR_TX];
   assign clr_rx = reg_wr && (reg_addr == `RFPH_CLEAR_OFS) && reg_wdata[`RFPH_CLR_RX];

   // ==========================================
   // queues
   rfph_queue u_txq (
      .core_clk  (core_clk),
      .srst      (srst),
      .clear     (clr_tx),
      .big       (ctrl_reg[`RFPH_CTRL_SHARED] & ~ctrl_reg[`RFPH_CTRL_RX_GO]),
      .push      (wr_txq),
      .push_data (reg_wdata),
      .pop       (txq_pop),
      .pop_data  (txq_data),
      .fill      (txq_fill),
      .full      (txq_full),
      .empty     (txq_empty)
   );

   rfph_queue u_rxq (
      .core_clk  (core_clk),
      .srst      (srst),
      .clear     (clr_rx),
      .big       (ctrl_reg[`RFPH_CTRL_SHARED] & ~ctrl_reg[`RFPH_CTRL_TX_GO]),
      .push      (rxq_push),
      .push_data (rxq_pdata),
      .pop       (rd_rxq),
      .pop_data  (rxq_data),
      .fill      (rxq_fill),
      .full      (rxq_full),
      .empty     (rxq_empty)
   );

   // ==========================================
   // transmit framer
   localparam TX_IDLE = 3'd0, TX_PRE = 3'd1, TX_SYNC = 3'd2, TX_HDR = 3'd3,
              TX_LEN = 3'd4, TX_PAY = 3'd5, TX_CRC = 3'd6, TX_LOAD = 3'd7;
   reg [2:0] tx_st_reg, tx_ret_reg;
   reg [7:0] tx_sh_reg, tx_cnt_reg, tx_crc_reg, tx_wh_reg;
   reg [3:0] tx_bitn_reg;
   reg       tx_half_reg, tx_busy_reg, tx_sent;
   wire      ph_tx = ctrl_reg[`RFPH_CTRL_PH_TX];
   wire      tx_byte_done = tx_busy_reg && tx_bit_ready && tx_bitn_reg == 4'd7 &&
                            (!cfg_reg[`RFPH_CFG_MANCH] || tx_half_reg);
   wire      raw_bit = tx_sh_reg[7];
   // the length byte also shifts in TX_PAY; only counted payload bytes are whitened
   wire      tx_in_pay = (tx_st_reg == TX_PAY) && (tx_cnt_reg != 8'h00);
   wire      wh_bit  = raw_bit ^ (cfg_reg[`RFPH_CFG_WHITE] & tx_wh_reg[7] & tx_in_pay);

   // the line shows the bit that the modem takes on this very edge
   always @* begin
      tx_bit_valid = tx_busy_reg;
      tx_bit       = cfg_reg[`RFPH_CFG_MANCH] ? (wh_bit ^ tx_half_reg) : wh_bit;
   end

   // loading a byte into the serialiser
   task load_byte;
      input [7:0] b;
      input [2:0] nxt;
      begin
         tx_sh_reg   <= b;
         tx_bitn_reg <= 4'd0;
         tx_half_reg <= 1'b0;
         tx_busy_reg <= 1'b1;
         tx_st_reg   <= nxt;
      end
   endtask

   always @(posedge core_clk) begin
      tx_sent <= 1'b0;
      txq_pop <= 1'b0;
      if (srst) begin
         tx_st_reg <= TX_IDLE; tx_ret_reg <= TX_IDLE; tx_sh_reg <= 8'h00;
         tx_cnt_reg <= 8'h00; tx_crc_reg <= `RFPH_CRC_SEED; tx_wh_reg <= `RFPH_WHITE_SEED;
         tx_bitn_reg <= 4'd0; tx_half_reg <= 1'b0; tx_busy_reg <= 1'b0;
      end else begin
         if (tx_busy_reg && tx_bit_ready) begin
            if (cfg_reg[`RFPH_CFG_MANCH] && !tx_half_reg)
               tx_half_reg <= 1'b1;
            else begin
               tx_half_reg <= 1'b0;
               tx_sh_reg   <= {tx_sh_reg[6:0], 1'b0};
               tx_bitn_reg <= tx_bitn_reg + 4'd1;
               if (tx_in_pay)
                  tx_wh_reg <= lfsr_step(tx_wh_reg);
               if (tx_byte_done)
                  tx_busy_reg <= 1'b0;
            end
         end
         if (!tx_busy_reg || tx_byte_done) begin
            case (tx_st_reg)
               TX_IDLE:
                  if (ctrl_reg[`RFPH_CTRL_TX_GO] && !txq_empty) begin
                     tx_crc_reg <= `RFPH_CRC_SEED;
                     tx_wh_reg  <= `RFPH_WHITE_SEED;
                     tx_cnt_reg <= 8'h00;
                     if (ph_tx && cfg_reg[`RFPH_CFG_PRE]) tx_st_reg <= TX_PRE;
                     else if (ph_tx && cfg_reg[`RFPH_CFG_SYNC]) tx_st_reg <= TX_SYNC;
                     else tx_st_reg <= TX_PAY;
                  end
               TX_PRE: begin
                  tx_cnt_reg <= tx_cnt_reg + 8'h01;
                  load_byte(`RFPH_PRE_BYTE,
                     (tx_cnt_reg == `RFPH_PRE_TX_BYTES - 8'h01) ? TX_SYNC : TX_PRE);
               end
               TX_SYNC: load_byte(cfg_reg[`RFPH_CFG_SYNC] ? sync_reg : `RFPH_PRE_BYTE,
                                  TX_HDR);
               TX_HDR: begin
                  tx_cnt_reg <= 8'h00;
                  if (cfg_reg[`RFPH_CFG_HDR]) begin
                     tx_crc_reg <= crc8_step(tx_crc_reg, hdr_reg);
                     load_byte(hdr_reg, TX_LEN);
                  end else tx_st_reg <= TX_LEN;
               end
               TX_LEN:
                  if (cfg_reg[`RFPH_CFG_LEN]) begin
                     tx_crc_reg <= crc8_step(tx_crc_reg, len_reg);
                     load_byte(len_reg, TX_PAY);
                  end else tx_st_reg <= TX_PAY;
               TX_PAY:
                  if (txq_empty || (ph_tx && tx_cnt_reg == len_reg))
                     tx_st_reg <= TX_CRC;
                  else begin
                     txq_pop    <= 1'b1;
                     tx_st_reg  <= TX_LOAD;
                  end
               TX_LOAD: begin // payload byte from the queue
                  tx_cnt_reg <= tx_cnt_reg + 8'h01;
                  tx_crc_reg <= crc8_step(tx_crc_reg, txq_data);
                  load_byte(txq_data, TX_PAY);
               end
               TX_CRC:
                  if (ph_tx && cfg_reg[`RFPH_CFG_CRC] && tx_ret_reg == TX_IDLE) begin
                     tx_ret_reg <= TX_CRC;
                     load_byte(tx_crc_reg, TX_CRC);
                  end else begin
                     tx_ret_reg <= TX_IDLE;
                     tx_sent    <= 1'b1;
                     tx_st_reg  <= TX_IDLE;
                  end
               default: tx_st_reg <= TX_IDLE;
            endcase
         end
      end
   end

   // ==========================================
   // receive checker
   localparam RX_HUNT = 3'd0, RX_SYNC = 3'd1, RX_HDR = 3'd2, RX_LEN = 3'd3,
              RX_PAY = 3'd4, RX_CRC = 3'd5;
   reg [2:0] rx_st_reg;
   reg [7:0] rx_sh_reg, rx_cnt_reg, rx_len_reg, rx_crc_reg, rx_wh_reg, rx_pre_reg, rx_key_reg;
   reg [2:0] rx_bitn_reg;
   reg       rx_half_reg, rx_first_reg;
   reg       rx_bit_ok;
   reg       rx_data;
   reg [7:0] rx_byte, rx_plain;
   wire      ph_rx = ctrl_reg[`RFPH_CTRL_PH_RX];

   // manchester pairs collapse to one bit; the first half carries the data
   always @* begin
      rx_bit_ok = rx_bit_valid && (!cfg_reg[`RFPH_CFG_MANCH] || rx_half_reg);
      rx_data   = cfg_reg[`RFPH_CFG_MANCH] ? rx_first_reg : rx_bit;
      rx_byte   = {rx_sh_reg[6:0], rx_data};
      rx_plain  = rx_byte ^ (cfg_reg[`RFPH_CFG_WHITE] ? {rx_key_reg[6:0], rx_wh_reg[7]} :
                  8'h00);
   end

   always @(posedge core_clk) begin
      rxq_push <= 1'b0;
      ev_rx <= 4'h0;
      if (srst || !ctrl_reg[`RFPH_CTRL_RX_GO]) begin
         rx_st_reg <= RX_HUNT; rx_sh_reg <= 8'h00; rx_cnt_reg <= 8'h00;
         rx_len_reg <= 8'h00; rx_crc_reg <= `RFPH_CRC_SEED; rx_wh_reg <= `RFPH_WHITE_SEED;
         rx_pre_reg <= 8'h00; rx_bitn_reg <= 3'd0; rx_half_reg <= 1'b0;
         rx_first_reg <= 1'b0; rxq_pdata <= 8'h00; rx_key_reg <= 8'h00;
      end else begin
         if (rx_bit_valid) begin
            rx_half_reg  <= cfg_reg[`RFPH_CFG_MANCH] & ~rx_half_reg;
            rx_first_reg <= rx_bit;
         end
         if (rx_bit_ok) begin
            rx_sh_reg   <= rx_byte;
            rx_bitn_reg <= rx_bitn_reg + 3'd1;
            if (rx_st_reg == RX_PAY) begin
               rx_wh_reg  <= lfsr_step(rx_wh_reg);
               rx_key_reg <= {rx_key_reg[6:0], rx_wh_reg[7]};
            end
            case (rx_st_reg)
               RX_HUNT: begin // bit-aligned preamble search
                  rx_bitn_reg <= 3'd0;
                  if (!ph_rx || !cfg_reg[`RFPH_CFG_PRE]) rx_st_reg <= RX_SYNC;
                  else if (rx_byte == `RFPH_PRE_BYTE || rx_byte == ~`RFPH_PRE_BYTE) begin
                     if (rx_pre_reg == `RFPH_PRE_RX_BYTES * 8'd8 - 8'd1) begin
                        ev_rx[`RFPH_EV_PRE_OK] <= 1'b1;
                        rx_st_reg <= RX_SYNC;
                     end else rx_pre_reg <= rx_pre_reg + 8'h01;
                  end else rx_pre_reg <= 8'h00;
               end
               RX_SYNC: begin
                  rx_bitn_reg <= 3'd0;
                  rx_crc_reg  <= `RFPH_CRC_SEED;
                  rx_wh_reg   <= `RFPH_WHITE_SEED;
                  rx_cnt_reg  <= 8'h00;
                  rx_len_reg  <= len_reg;
                  if (!ph_rx || !cfg_reg[`RFPH_CFG_SYNC] || rx_byte == sync_reg) begin
                     ev_rx[`RFPH_EV_SYNC_OK] <= 1'b1;
                     rx_st_reg <= (ph_rx && cfg_reg[`RFPH_CFG_HDR]) ? RX_HDR :
                                  (ph_rx && cfg_reg[`RFPH_CFG_LEN]) ? RX_LEN : RX_PAY;
                  end
               end
               default:
                  if (rx_bitn_reg == 3'd7) begin
                     case (rx_st_reg)
                        RX_HDR:
                           if (rx_byte == hdr_reg) begin
                              rx_crc_reg <= crc8_step(rx_crc_reg, rx_byte);
                              rx_st_reg  <= cfg_reg[`RFPH_CFG_LEN] ? RX_LEN : RX_PAY;
                           end else begin
                              rx_st_reg  <= RX_HUNT;
                              rx_pre_reg <= 8'h00;
                           end
                        RX_LEN: begin
                           rx_crc_reg <= crc8_step(rx_crc_reg, rx_byte);
                           rx_len_reg <= rx_byte;
                           rx_st_reg  <= (rx_byte == 8'h00) ? RX_CRC : RX_PAY;
                        end
                        RX_PAY: begin
                           rxq_pdata  <= rx_plain;
                           rxq_push   <= 1'b1;
                           rx_crc_reg <= crc8_step(rx_crc_reg, rx_plain);
                           rx_cnt_reg <= rx_cnt_reg + 8'h01;
                           if (rx_cnt_reg + 8'h01 == rx_len_reg)
                              rx_st_reg <= (ph_rx && cfg_reg[`RFPH_CFG_CRC]) ? RX_CRC : RX_HUNT;
                           if (rx_cnt_reg + 8'h01 == rx_len_reg &&
                               !(ph_rx && cfg_reg[`RFPH_CFG_CRC]))
                              ev_rx[`RFPH_EV_PKT_OK] <= ph_rx;
                        end
                        RX_CRC: begin
                           ev_rx[`RFPH_EV_PKT_OK]  <= (rx_byte == rx_crc_reg);
                           ev_rx[`RFPH_EV_CRC_ERR] <= (rx_byte != rx_crc_reg);
                           rx_st_reg  <= RX_HUNT;
                           rx_pre_reg <= 8'h00;
                        end
                        default: rx_st_reg <= RX_HUNT;
                     endcase
                  end
            endcase
         end
      end
   end

   // ==========================================
   // threshold events and register file
   always @* begin
      ev_set = {ev_rx, 3'b000};
      ev_set[`RFPH_EV_TX_AE] = (txq_fill <= tx_ae_reg) && (prev_tx_fill > tx_ae_reg);
      ev_set[`RFPH_EV_RX_AF] = (rxq_fill >= rx_af_reg) && (prev_rx_fill < rx_af_reg) &&
                               (rx_af_reg != 8'h00);
      ev_set[`RFPH_EV_SENT]  = tx_sent;
   end

   always @(posedge core_clk) begin
      if (srst) begin
         ctrl_reg <= `RFPH_CTRL_RST; cfg_reg <= `RFPH_CFG_RST; tx_ae_reg <= `RFPH_TX_AE_RST;
         rx_af_reg <= `RFPH_RX_AF_RST; sync_reg <= `RFPH_SYNC_RST; hdr_reg <= `RFPH_HDR_RST;
         len_reg <= `RFPH_LEN_RST; event_reg <= 7'h00; int_en_reg <= 7'h00;
         prev_tx_fill <= 8'h00; prev_rx_fill <= 8'h00;
         reg_rdata <= 8'h00; interrupt_request_n <= 1'b1;
      end else begin
         prev_tx_fill <= txq_fill;
         prev_rx_fill <= rxq_fill;
         // new events beat a same-cycle write-one-to-clear
         event_reg <= (event_reg & ~((reg_wr && reg_addr == `RFPH_EVENT_OFS) ?
                       reg_wdata[6:0] : 7'h00)) | ev_set;
         if (tx_sent && txq_empty)
            ctrl_reg[`RFPH_CTRL_TX_GO] <= 1'b0;
         if (reg_wr) begin
            case (reg_addr)
               `RFPH_CTRL_OFS:    ctrl_reg   <= reg_wdata;
               `RFPH_PKT_CFG_OFS: cfg_reg    <= reg_wdata;
               `RFPH_TX_AE_OFS:   tx_ae_reg  <= reg_wdata;
               `RFPH_RX_AF_OFS:   rx_af_reg  <= reg_wdata;
               `RFPH_SYNC_OFS:    sync_reg   <= reg_wdata;
               `RFPH_HDR_OFS:     hdr_reg    <= reg_wdata;
               `RFPH_LEN_OFS:     len_reg    <= reg_wdata;
               `RFPH_INT_EN_OFS:  int_en_reg <= reg_wdata[6:0];
               default:           ;
            endcase
         end
         interrupt_request_n <= ~|(event_reg & int_en_reg);
         if (reg_rd) begin
            case (reg_addr)
               `RFPH_CTRL_OFS:    reg_rdata <= ctrl_reg;
               `RFPH_PKT_CFG_OFS: reg_rdata <= cfg_reg;
               `RFPH_TX_AE_OFS:   reg_rdata <= tx_ae_reg;
               `RFPH_RX_AF_OFS:   reg_rdata <= rx_af_reg;
               `RFPH_SYNC_OFS:    reg_rdata <= sync_reg;
               `RFPH_HDR_OFS:     reg_rdata <= hdr_reg;
               `RFPH_LEN_OFS:     reg_rdata <= len_reg;
               `RFPH_STATUS_OFS:  reg_rdata <= {4'h0, rxq_full, rxq_empty, txq_full, txq_empty};
               `RFPH_EVENT_OFS:   reg_rdata <= {1'b0, event_reg};
               `RFPH_INT_EN_OFS:  reg_rdata <= {1'b0, int_en_reg};
               `RFPH_TXQ_CNT_OFS: reg_rdata <= txq_fill;
               `RFPH_RXQ_CNT_OFS: reg_rdata <= rxq_fill;
               `RFPH_RXQ_RD_OFS:  reg_rdata <= rxq_data;
               default:           reg_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule // rfph_top

//--- test/rfph_asserts.sv
/* port checker for rfph_top, bound below; assumes one clock and srst. */
`timescale 1ns/1ps
module rfph_asserts (
   input wire       core_clk,
   input wire       srst,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   input wire       tx_bit_ready,
   input wire       tx_bit,
   input wire       tx_bit_valid,
   input wire       interrupt_request_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   a_reset_idle: assert property (
      $fell(srst) |-> reg_rdata == 8'h00 && interrupt_request_n) else $error("busy after reset");
   a_no_early_tx: assert property (
      $fell(srst) |-> !tx_bit_valid [*8]) else $error("early transmit");
   a_rdata_holds: assert property (
      !$past(reg_rd) |-> $stable(reg_rdata)) else $error("read data moved");
   a_unmapped_zero: assert property (
      reg_rd && reg_addr == 8'hff |=> reg_rdata == 8'h00) else $error("unmapped not zero");
   a_stall_holds: assert property (
      tx_bit_valid && !tx_bit_ready |=> tx_bit_valid && $stable(tx_bit)) else $error("bit lost");
   a_irq_masked: assert property (
      reg_wr && reg_addr == 8'h22 && reg_wdata == 8'h00 |-> ##2 interrupt_request_n)
      else $error("irq while masked");
   a_clear_empties: assert property (
      reg_wr && reg_addr == 8'h25 && reg_wdata == 8'h03 ##2 reg_rd && reg_addr == 8'h20
      |=> reg_rdata[2] && reg_rdata[0]) else $error("not empty after clear");
   a_push_counts: assert property (
      reg_wr && reg_addr == 8'h25 && reg_wdata == 8'h01 ##2 reg_wr && reg_addr == 8'h66
      ##2 reg_rd && reg_addr == 8'h23 |=> reg_rdata == 8'h01) else $error("push not counted");
endmodule // rfph_asserts
bind rfph_top rfph_asserts u_chk (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .tx_bit_ready, .tx_bit, .tx_bit_valid, .interrupt_request_n);

//--- test/rfph_modem.sv
/* modem model: takes transmit bits and hands each back as a received bit. */
`timescale 1ns/1ps
module rfph_modem (
   input  wire core_clk,
   input  wire tx_bit,
   input  wire tx_bit_valid,
   output reg  tx_bit_ready = 1'b0,
   output reg  rx_bit = 1'b0,
   output reg  rx_bit_valid = 1'b0
);
   always @(posedge core_clk) begin
      tx_bit_ready <= ~tx_bit_ready; // stalls every other cycle to test the hold
      rx_bit_valid <= tx_bit_valid && tx_bit_ready;
      rx_bit <= tx_bit_valid && tx_bit_ready ? tx_bit : ~rx_bit; // idle line never repeats
   end
endmodule // rfph_modem

//--- test/rfph_top_test.sv
/* bench for rfph_top; the modem model loops transmit bits back into receive. */
`timescale 1ns/1ps
module rfph_top_test;
   reg        core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   reg  [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
   wire [7:0] reg_rdata;
   wire       tx_bit_ready, tx_bit, tx_bit_valid, rx_bit, rx_bit_valid, interrupt_request_n;
   integer    err_count = 0, total_checks = 0, i;
   rfph_top uut (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .tx_bit_ready, .tx_bit, .tx_bit_valid, .rx_bit, .rx_bit_valid, .interrupt_request_n);
   rfph_modem modem (.core_clk, .tx_bit, .tx_bit_valid, .tx_bit_ready, .rx_bit, .rx_bit_valid);
   initial forever #12.5 core_clk = ~core_clk;
   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input [63:0] nm, input [7:0] s, input [7:0] e);
      total_checks = total_checks + 1;
      if (s !== e) begin
         err_count = err_count + 1;
         $display("[ERR] %0s expected %h seen %h", nm, e, s);
      end
   endtask
   task bus(input w, input [7:0] a, input [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 d = reg_rdata; // read byte is registered on the strobe edge and holds until the next read
   endtask
   task poll(input [7:0] m);
      d = 8'h00;
      for (i = 0; i < 600 && (d & m) === 8'h00; i = i + 1) bus(0, 8'h21, 8'h00);
      if (i == 600) begin
         err_count = err_count + 1;
         tally_and_finish;
      end
   endtask
   task t_fifo;
      bus(0, 8'hff, 8'h00);
      chk("unmapped", d, 8'h00);
      bus(1, 8'h25, 8'h01);
      bus(1, 8'h66, 8'h00);
      bus(0, 8'h23, 8'h00);
      chk("onepush", d, 8'h01);
      for (i = 1; i < 65; i = i + 1) bus(1, 8'h66, i[7:0]);
      bus(0, 8'h23, 8'h00);
      chk("txfill", d, 8'h40);
      bus(1, 8'h25, 8'h03);
      bus(0, 8'h20, 8'h00);
      chk("status", d, 8'h05);
      bus(1, 8'h10, 8'h14);
      for (i = 0; i < 130; i = i + 1) bus(1, 8'h66, i[7:0]);
      bus(0, 8'h23, 8'h00);
      chk("shared", d, 8'h81);
      bus(1, 8'h25, 8'h03);
      bus(1, 8'h10, 8'h00);
      $display("t_fifo done");
   endtask
   task t_loop;
      bus(1, 8'h13, 8'h04);
      bus(1, 8'h12, 8'h04);
      bus(1, 8'h21, 8'h7f);
      bus(1, 8'h22, 8'h20);
      for (i = 0; i < 8; i = i + 1) bus(1, 8'h66, 8'h30 + i[7:0]);
      bus(1, 8'h10, 8'h0f);
      poll(8'h20);
      bus(0, 8'h21, 8'h00);
      chk("events", d & 8'h7f, 8'h3f);
      chk("irq", {7'h00, interrupt_request_n}, 8'h00);
      bus(0, 8'h24, 8'h00);
      chk("rxfill", d, 8'h08);
      for (i = 0; i < 8; i = i + 1) begin
         bus(0, 8'h77, 8'h00);
         chk("rxbyte", d, 8'h30 + i[7:0]);
      end
      bus(0, 8'h10, 8'h00);
      chk("txgo", d & 8'h01, 8'h00);
      bus(1, 8'h22, 8'h00);
      $display("t_loop done");
   endtask
   task t_coded;
      bus(1, 8'h21, 8'h7f);
      bus(1, 8'h11, 8'h7f);
      for (i = 0; i < 8; i = i + 1) bus(1, 8'h66, 8'hc5 ^ i[7:0]);
      bus(1, 8'h10, 8'h0f);
      poll(8'h20);
      bus(0, 8'h21, 8'h00);
      chk("coded", d & 8'h60, 8'h20);
      for (i = 0; i < 8; i = i + 1) begin
         bus(0, 8'h77, 8'h00);
         chk("cbyte", d, 8'hc5 ^ i[7:0]);
      end
      $display("t_coded done");
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      t_fifo;
      t_loop;
      t_coded;
      tally_and_finish;
   end
endmodule // rfph_top_test
